// File: dgp_consts.svh
`ifndef DGP_CONSTS_SVH
`define DGP_CONSTS_SVH
// register indices; the bus byte address is index*4
`define DGP_IDX_A_DIR 12'h2C0
`define DGP_IDX_A_PIN 12'h2C2
`define DGP_IDX_A_LAT 12'h2C4
`define DGP_IDX_A_ODC 12'h2C6
`define DGP_IDX_B_DIR 12'h2C8
`define DGP_IDX_B_PIN 12'h2CA
`define DGP_IDX_B_LAT 12'h2CC
`define DGP_IDX_B_ODC 12'h2CE
`define DGP_IDX_CFG 12'h2D0
`define DGP_ADDR_W 14
// reset values
`define DGP_A_DIR_RST 16'h00DF
`define DGP_B_DIR_RST 16'hFFFF
`define DGP_ODC_RST 16'h0000
`define DGP_LAT_RST 16'h0000
`define DGP_CFG_RST 16'h0000
// implemented bit masks
`define DGP_A_FULL_MASK 16'h00DF
`define DGP_A_BIT7_MASK 16'h0080
`define DGP_B_FULL_MASK 16'hFFFF
`define DGP_B_SMALL_GONE 16'h0C68
`define DGP_A_BIT5_MASK 16'h0020
`define DGP_A_DBG2_MASK 16'h0003
`define DGP_A_DBG3_MASK 16'h0010
`define DGP_B_DBG1_MASK 16'h0003
`define DGP_B_DBG3_MASK 16'h0010
`define DGP_A_OSC2_MASK 16'h0004
`define DGP_A_OSC3_MASK 16'h0008
// configuration register fields
`define DGP_CFG_SMALL 0
`define DGP_CFG_RSTPIN 1
`define DGP_CFG_OSC_LO 2
`define DGP_CFG_OSC_HI 3
`define DGP_CFG_CLOCK_OUTPUT_FUNCTION 4
`define DGP_CFG_DBG1 5
`define DGP_CFG_DBG2 6
`define DGP_CFG_DBG3 7
`define DGP_CFG_MASK 16'h00FF
`define DGP_OSC_OFF 2'h0
`define DGP_OSC_EXT 2'h3
`endif

// File: dgp_pkg.sv
`default_nettype none
package dgp_pkg;
  typedef enum {DGP_IDLE, DGP_ANSWER} dgp_bus_state_t;
endpackage
`default_nettype wire

// File: dgp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgp_consts.svh"
// one 16-bit port: direction, latch, open drain and pin drive
module dgp_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] impl_mask,
  input wire logic [15:0] dir_rst,
  input wire logic dir_we,
  input wire logic lat_we,
  input wire logic odc_we,
  input wire logic [15:0] wdata,
  input wire logic [15:0] pin_in,
  output logic [15:0] dir_reg,
  output logic [15:0] lat_reg,
  output logic [15:0] odc_reg,
  output logic [15:0] pin_sample_reg,
  output logic [15:0] pin_out_reg,
  output logic [15:0] pin_oe_b_reg
);
  logic [15:0] dir_next;
  logic [15:0] lat_next;
  logic [15:0] odc_next;
  assign dir_next = wdata & impl_mask;
  assign lat_next = wdata & impl_mask;
  assign odc_next = wdata & impl_mask;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dir_reg <= dir_rst;
    end else if (dir_we) begin
      dir_reg <= dir_next;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lat_reg <= `DGP_LAT_RST;
    end else if (lat_we) begin
      lat_reg <= lat_next;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      odc_reg <= `DGP_ODC_RST;
    end else if (odc_we) begin
      odc_reg <= odc_next;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_sample_reg <= 16'h0000;
    end else begin
      pin_sample_reg <= pin_in;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_out_reg <= 16'h0000;
      pin_oe_b_reg <= 16'hFFFF;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (dir_reg[i] || !impl_mask[i]) begin
          pin_out_reg[i] <= 1'b0;
          pin_oe_b_reg[i] <= 1'b1;
        end else if (odc_reg[i]) begin
          pin_out_reg[i] <= 1'b0;
          pin_oe_b_reg[i] <= lat_reg[i];
        end else begin
          pin_out_reg[i] <= lat_reg[i];
          pin_oe_b_reg[i] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: dgp_gpio.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgp_consts.svh"
// How it works
// - unimplemented port bits read zero, except bits dropped by small package keep old dir/lat/odc values until that register is next written
// - A5 input only when reset pin off
// - second debug pair zeroes A1, A0
// - third debug pair zeroes A4
// - A7 absent on small package
// - A2, A3 need oscillator mode 00
// - A3 also needs clock output off
// - first debug pair zeroes B1, B0
// - third debug pair zeroes B4
// - B11,10,6,5,3 absent on small package
module dgp_gpio (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [`DGP_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [15:0] PORT_A_IN,
  output logic [15:0] PORT_A_OUT,
  output logic [15:0] PORT_A_OE_B,
  input wire logic [15:0] PORT_B_IN,
  output logic [15:0] PORT_B_OUT,
  output logic [15:0] PORT_B_OE_B
);
  ////////////////////////////////////////////////////////////////////////////
  dgp_pkg::dgp_bus_state_t state_reg;
  logic [15:0] cfg_reg;
  logic [15:0] a_mask;
  logic [15:0] b_mask;
  logic [15:0] a_dir;
  logic [15:0] a_lat;
  logic [15:0] a_odc;
  logic [15:0] a_smp;
  logic [15:0] b_dir;
  logic [15:0] b_lat;
  logic [15:0] b_odc;
  logic [15:0] b_smp;
  logic [15:0] a_read_gate;
  logic [15:0] b_read_gate;
  logic [15:0] wdata;
  logic [15:0] rdata_next;
  logic [1:0] osc_mode;
  logic small_pkg;
  logic req;
  logic wr_ok;
  logic hit;
  logic a_dir_we;
  logic a_lat_we;
  logic a_odc_we;
  logic b_dir_we;
  logic b_lat_we;
  logic b_odc_we;
  logic cfg_we;
  logic [`DGP_ADDR_W-3:0] idx;
  assign small_pkg = cfg_reg[`DGP_CFG_SMALL];
  assign osc_mode = cfg_reg[`DGP_CFG_OSC_HI:`DGP_CFG_OSC_LO];
  ////////////////////////////////////////////////////////////////////////////
  // implemented bits per package
  // drop A7 on small package
  assign a_mask = small_pkg ? (`DGP_A_FULL_MASK & ~`DGP_A_BIT7_MASK) : `DGP_A_FULL_MASK;
  // drop B bits on small package
  assign b_mask = small_pkg ? (`DGP_B_FULL_MASK & ~`DGP_B_SMALL_GONE) : `DGP_B_FULL_MASK;
  // pin-level read gating
  always_comb begin
    a_read_gate = a_mask;
    // A5 input only with reset pin off
    if (!cfg_reg[`DGP_CFG_RSTPIN]) begin
      a_read_gate = a_read_gate | `DGP_A_BIT5_MASK;
    end
    if (cfg_reg[`DGP_CFG_DBG2]) begin
      a_read_gate = a_read_gate & ~`DGP_A_DBG2_MASK;
    end
    if (cfg_reg[`DGP_CFG_DBG3]) begin
      a_read_gate = a_read_gate & ~`DGP_A_DBG3_MASK;
    end
    if (osc_mode != `DGP_OSC_OFF) begin
      a_read_gate = a_read_gate & ~`DGP_A_OSC2_MASK;
    end
    // A3 also needs clock output off
    if (!((osc_mode == `DGP_OSC_OFF || osc_mode == `DGP_OSC_EXT) &&
          !cfg_reg[`DGP_CFG_CLOCK_OUTPUT_FUNCTION]) || osc_mode != `DGP_OSC_OFF) begin
      a_read_gate = a_read_gate & ~`DGP_A_OSC3_MASK;
    end
  end
  always_comb begin
    b_read_gate = b_mask;
    if (cfg_reg[`DGP_CFG_DBG1]) begin
      b_read_gate = b_read_gate & ~`DGP_B_DBG1_MASK;
    end
    if (cfg_reg[`DGP_CFG_DBG3]) begin
      b_read_gate = b_read_gate & ~`DGP_B_DBG3_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on second edge
  assign req = (AVS_READ || AVS_WRITE) && state_reg == dgp_pkg::DGP_IDLE;
  assign wr_ok = req && AVS_WRITE && AVS_BYTEENABLE[1:0] != 2'h0;
  assign idx = AVS_ADDRESS[`DGP_ADDR_W-1:2];
  assign wdata = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : 8'h00,
                  AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : 8'h00};
  always_comb begin
    a_dir_we = 1'b0;
    a_lat_we = 1'b0;
    a_odc_we = 1'b0;
    b_dir_we = 1'b0;
    b_lat_we = 1'b0;
    b_odc_we = 1'b0;
    cfg_we = 1'b0;
    hit = 1'b1;
    rdata_next = 16'h0000;
    if (AVS_ADDRESS[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx == `DGP_IDX_A_DIR) begin
      a_dir_we = wr_ok;
      rdata_next = a_dir;
    end else if (idx == `DGP_IDX_A_PIN) begin
      a_lat_we = wr_ok;
      rdata_next = a_smp & a_read_gate;
    end else if (idx == `DGP_IDX_A_LAT) begin
      a_lat_we = wr_ok;
      rdata_next = a_lat;
    end else if (idx == `DGP_IDX_A_ODC) begin
      a_odc_we = wr_ok;
      rdata_next = a_odc;
    end else if (idx == `DGP_IDX_B_DIR) begin
      b_dir_we = wr_ok;
      rdata_next = b_dir;
    end else if (idx == `DGP_IDX_B_PIN) begin
      b_lat_we = wr_ok;
      rdata_next = b_smp & b_read_gate;
    end else if (idx == `DGP_IDX_B_LAT) begin
      b_lat_we = wr_ok;
      rdata_next = b_lat;
    end else if (idx == `DGP_IDX_B_ODC) begin
      b_odc_we = wr_ok;
      rdata_next = b_odc;
    end else if (idx == `DGP_IDX_CFG) begin
      cfg_we = wr_ok;
      rdata_next = cfg_reg;
    end else begin
      hit = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_reg <= dgp_pkg::DGP_IDLE;
    end else begin
      case (state_reg)
        dgp_pkg::DGP_IDLE: begin
          if (req) begin
            state_reg <= dgp_pkg::DGP_ANSWER;
          end
        end
        default: begin
          state_reg <= dgp_pkg::DGP_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !req;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      AVS_READDATA <= 32'h00000000;
    end else if (req && AVS_READ && hit) begin
      AVS_READDATA <= {16'h0000, rdata_next};
    end else begin
      AVS_READDATA <= 32'h00000000;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      cfg_reg <= `DGP_CFG_RST;
    end else if (cfg_we) begin
      cfg_reg <= wdata & `DGP_CFG_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  dgp_port u_port_a (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .impl_mask(a_mask),
    .dir_rst(`DGP_A_DIR_RST),
    .dir_we(a_dir_we),
    .lat_we(a_lat_we),
    .odc_we(a_odc_we),
    .wdata(wdata),
    .pin_in(PORT_A_IN),
    .dir_reg(a_dir),
    .lat_reg(a_lat),
    .odc_reg(a_odc),
    .pin_sample_reg(a_smp),
    .pin_out_reg(PORT_A_OUT),
    .pin_oe_b_reg(PORT_A_OE_B)
  );
  dgp_port u_port_b (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .impl_mask(b_mask),
    .dir_rst(`DGP_B_DIR_RST),
    .dir_we(b_dir_we),
    .lat_we(b_lat_we),
    .odc_we(b_odc_we),
    .wdata(wdata),
    .pin_in(PORT_B_IN),
    .dir_reg(b_dir),
    .lat_reg(b_lat),
    .odc_reg(b_odc),
    .pin_sample_reg(b_smp),
    .pin_out_reg(PORT_B_OUT),
    .pin_oe_b_reg(PORT_B_OE_B)
  );
endmodule
`default_nettype wire

// File: dgp_pins.sv
`timescale 1ns/1ps
`default_nettype none
// board side of one port: driven bits follow the pad, released bits the board
module dgp_pins (
  input wire logic [15:0] out,
  input wire logic [15:0] oe_b,
  input wire logic [15:0] board,
  output logic [15:0] pin
);
  assign pin = (out & ~oe_b) | (board & oe_b);
endmodule
`default_nettype wire

// File: dgp_gpio_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dgp_gpio_checker (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [13:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [15:0] PORT_A_OUT,
  input wire logic [15:0] PORT_A_OE_B,
  input wire logic [15:0] PORT_B_OE_B
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_wait_one_cycle: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  a_req_answered: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  a_no_spurious: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");
  a_idle_data_zero: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h00000000)
    else $error("read data outside answer");
  a_upper_half_zero: assert property (AVS_READDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_port_a_upper: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[13:5] == 9'h058
    |-> AVS_READDATA[15:8] == 8'h00)
    else $error("port a upper byte not zero");
  a_bit5_never_driven: assert property (PORT_A_OE_B[5] && PORT_A_OE_B[15:8] == 8'hFF)
    else $error("unimplemented port a bit driven");
  a_reset_outputs: assert property (@(posedge SYS_CLK) disable iff (1'b0) !RST_B |=>
    AVS_WAITREQUEST && PORT_A_OE_B == 16'hFFFF && PORT_B_OE_B == 16'hFFFF &&
    PORT_A_OUT == 16'h0000)
    else $error("outputs not reset");
endmodule
bind dgp_gpio dgp_gpio_checker i_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE_B(PORT_A_OE_B),
  .PORT_B_OE_B(PORT_B_OE_B));
`default_nettype wire

// File: dgp_gpio_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dgp_consts.svh"
module dgp_gpio_tb_top;
  logic SYS_CLK = 1'b0, RST_B = 1'b0, rd_r = 1'b0, wr_r = 1'b0, wreq;
  logic [13:0] adr = 14'h0000;
  logic [31:0] wd = 32'h00000000, rdata, rq;
  logic [3:0] be = 4'h0;
  logic [15:0] a_out, a_oe_b, b_out, b_oe_b, a_pin, b_pin, board = 16'hFFFF;
  logic [15:0] cv [11] = '{16'h00, 16'h00, 16'h02, 16'h04, 16'h08, 16'h0C, 16'h10, 16'h20, 16'h40,
    16'h80, 16'h01};
  logic [15:0] ea [11] = '{16'h00FF, 16'h00A5, 16'h00DF, 16'h00F3, 16'h00F3, 16'h00F3, 16'h00F7,
    16'h00FF, 16'h00FC, 16'h00EF, 16'h007F};
  logic [15:0] eb [11] = '{16'hFFFF, 16'hA5A5, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFC, 16'hFFFF, 16'hFFEF, 16'hF397};
  int failures = 0, comparisons = 0, cycles = 0;
  dgp_gpio i_dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .AVS_ADDRESS(adr), .AVS_READ(rd_r),
    .AVS_WRITE(wr_r), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .PORT_A_IN(a_pin), .PORT_A_OUT(a_out), .PORT_A_OE_B(a_oe_b),
    .PORT_B_IN(b_pin), .PORT_B_OUT(b_out), .PORT_B_OE_B(b_oe_b));
  dgp_pins i_pa (.out(a_out), .oe_b(a_oe_b), .board(board), .pin(a_pin));
  dgp_pins i_pb (.out(b_out), .oe_b(b_oe_b), .board(board), .pin(b_pin));
  initial forever #50 SYS_CLK = ~SYS_CLK;
  task final_report;
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [11:0] i, input logic [15:0] d, input logic [3:0] e);
    @(posedge SYS_CLK);
    rd_r <= !w;
    wr_r <= w;
    adr <= {i, 2'h0};
    wd <= {16'h0000, d};
    be <= e;
    do @(posedge SYS_CLK); while (wreq !== 1'b0);
    rq = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask
  task wr(input logic [11:0] i, input logic [15:0] d);
    acc(1'b1, i, d, 4'h3);
  endtask
  task rc(input logic [11:0] i, input logic [15:0] e);
    acc(1'b0, i, 16'h0000, 4'hF);
    chk(rq, {16'h0000, e});
  endtask
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rc(`DGP_IDX_A_DIR, 16'h00DF);
    rc(`DGP_IDX_B_DIR, 16'hFFFF);
    rc(`DGP_IDX_A_ODC, 16'h0000);
    rc(`DGP_IDX_B_ODC, 16'h0000);
    wr(12'h2D4, 16'hFFFF);
    rc(12'h2D4, 16'h0000);
    for (int k = 0; k < 11; k++) begin
      board <= (k == 1) ? 16'hA5A5 : 16'hFFFF;
      wr(`DGP_IDX_CFG, cv[k]);
      rc(`DGP_IDX_A_PIN, ea[k]);
      rc(`DGP_IDX_B_PIN, eb[k]);
    end
    rc(`DGP_IDX_CFG, 16'h0001);
    wr(`DGP_IDX_B_LAT, 16'hFFFF);
    rc(`DGP_IDX_B_LAT, 16'hF397);
    wr(`DGP_IDX_A_DIR, 16'hFFFF);
    rc(`DGP_IDX_A_DIR, 16'h005F);
    wr(`DGP_IDX_CFG, 16'h0000);
    board <= 16'h0000;
    wr(`DGP_IDX_A_DIR, 16'h0000);
    wr(`DGP_IDX_A_PIN, 16'hFF55);
    acc(1'b1, `DGP_IDX_A_LAT, 16'h00FF, 4'h0);
    rc(`DGP_IDX_A_LAT, 16'h0055);
    rc(`DGP_IDX_A_PIN, 16'h0055);
    chk({a_oe_b, a_out & ~a_oe_b}, 32'hFF200055);
    wr(`DGP_IDX_A_ODC, 16'h00FF);
    rc(`DGP_IDX_A_PIN, 16'h0000);
    rc(`DGP_IDX_A_LAT, 16'h0055);
    chk({16'h0000, a_oe_b}, 32'h0000FF75);
    wr(`DGP_IDX_B_DIR, 16'h0000);
    wr(`DGP_IDX_B_PIN, 16'h1234);
    rc(`DGP_IDX_B_PIN, 16'h1234);
    chk({b_oe_b, b_out}, 32'h00001234);
    RST_B <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rc(`DGP_IDX_A_DIR, 16'h00DF);
    final_report();
  end
endmodule
`default_nettype wire
